// [hw/oss_pkg.sv]
// Constants, encodings and carrier types of the oscillator start-up block.
// Assumes a single 200 MHz system clock drives all of its logic.
package oss_pkg;

    // ****************************************
    // Primary mode encodings
    // ****************************************
    localparam logic [3:0] MODE_LP = 4'h0;
    localparam logic [3:0] MODE_XT = 4'h1;
    localparam logic [3:0] MODE_HS = 4'h2;
    localparam logic [3:0] MODE_RC = 4'h3;
    localparam logic [3:0] MODE_EC = 4'h4;
    localparam logic [3:0] MODE_HIGH_SPEED_CRYSTAL_PLL_MODE = 4'h6;
    localparam logic [3:0] MODE_RESISTOR_CAP_PIN_IO_MODE = 4'h7;
    localparam logic [3:0] MODE_INTIO = 4'h8;
    localparam logic [3:0] MODE_INTCK = 4'h9;

    // ****************************************
    // Reset values and field codes
    // ****************************************
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [2:0] FREQ_RST = 3'h3;
    localparam logic [2:0] FREQ_SLOW = 3'h0;
    localparam logic [2:0] FREQ_FAST = 3'h7;
    localparam logic [5:0] TUNE_RST = 6'h00;
    localparam logic [1:0] DRIVE_OFF = 2'h0;
    localparam logic [1:0] DRIVE_LOW = 2'h1;
    localparam logic [1:0] DRIVE_MID = 2'h2;
    localparam logic [1:0] DRIVE_HIGH = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam logic [9:0] OST_LAST = 10'h3ff;
    localparam logic [9:0] RC_LAST = 10'h007;
    localparam int PLL_LOCK_NS = 2000000;
    localparam int PLL_LOCK_CYC = PLL_LOCK_NS / CLK_PERIOD_NS;
    localparam int WARM_CYC = 64;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic clk_in_gpio;
        logic clk_out_gpio;
        logic clk_out;
        logic clk_out_oe;
    } oss_pins_t;

    typedef struct packed {
        logic primary_running;
        logic fast_stable;
        logic src_primary;
        logic src_secondary;
        logic src_internal;
    } oss_status_t;

endpackage

// [hw/oss_top.sv]
// Oscillator start-up timer, clock source selection and internal postscaler.
// Assumes configuration inputs are static and strobes come from i_clk_sys logic.
//
// Operation
// - Crystal modes count 1024 clock-input edges before releasing the core.
// - Count runs after power-on (after power-up timer if enabled) and each wake.
// - Program counter held and execution suspended while start-up runs.
// - High-speed crystal with PLL waits 1024 edges plus 2 ms.
// - Internal oscillator modes apply the warm-up delay before running.
// - External-clock mode has no start-up delay.
// - External-clock mode uses clock input pin, releases second pin as GPIO.
// - Fully static: clock stop halts with state kept, restart resumes.
// - Low, medium, high crystal modes pick low, mid, high amplifier drive.
// - RC mode drives oscillator frequency divided by 4 on clock output pin.
// - RC-with-I/O mode makes the second oscillator pin GPIO.
// - 16 MHz fast and 31 kHz slow oscillators; 3-bit select picks eight rates.
// - 2-bit system clock select chooses external or internal sources.
// - Internal-oscillator primary modes come from the 4-bit primary config field.
// - Internal clock-out mode: input pin GPIO, output pin carries rate divided by 4.
// - Internal I/O mode releases both oscillator pins as GPIO.
// - Fast oscillator on when upper select bit set and rate nonzero or low source set.
// - Fast oscillator also on for two-speed, fail-safe or internal primary.
// - A status bit reports whether the fast oscillator is stable.
// - Select decodes 1x internal, 01 secondary, 00 primary.
// - Rate 111 is 16 MHz direct, halving per step to 001, 000 slow.
// - Every reset clears the system clock select to primary.
// - Slow rate with low source set uses fast divided by 512, else slow oscillator.
`timescale 1ns/1ps

module oss_top #(
    parameter int PLL_CYC = oss_pkg::PLL_LOCK_CYC,
    parameter int WARM_CYCLES = oss_pkg::WARM_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Oscillator pins and internal oscillators
    input wire logic i_clk_in_pin,
    input wire logic i_fast_internal_osc,
    input wire logic i_slow_internal_osc,
    input wire logic i_fast_osc_ready,
    // Configuration
    input wire logic [3:0] i_primary_mode,
    input wire logic i_two_speed_startup_enable,
    input wire logic i_fail_safe_monitor_enable,
    input wire logic i_power_up_timer_enable,
    input wire logic i_power_up_timer_expired,
    input wire logic i_wake,
    // Control writes
    input wire logic i_sel_wr,
    input wire logic [1:0] i_sel_data,
    input wire logic i_freq_wr,
    input wire logic [2:0] i_freq_data,
    input wire logic i_tune_wr,
    input wire logic [5:0] i_tune_data,
    input wire logic i_low_freq_source_select,
    // Outputs
    output logic o_core_run,
    output logic o_hold_pc,
    output logic o_fast_osc_en,
    output logic o_int_clk,
    output logic [1:0] o_amp_drive,
    output logic [1:0] o_sys_clk_sel,
    output logic [2:0] o_freq_sel,
    output logic [5:0] o_tune,
    output oss_pkg::oss_pins_t o_pins,
    output oss_pkg::oss_status_t o_status
);

    // ****************************************
    // Reset release and input synchronisers
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;
    logic [3:0] in_meta_r;
    logic [3:0] in_sync_r;
    logic clk_in_prev_r;
    logic fast_prev_r;
    logic clk_in_s;
    logic fast_s;
    logic slow_s;
    logic ready_s;
    logic clk_in_edge;
    logic fast_edge;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            in_meta_r <= 4'h0;
            in_sync_r <= 4'h0;
            clk_in_prev_r <= 1'b0;
            fast_prev_r <= 1'b0;
        end else begin
            in_meta_r <= {i_fast_osc_ready, i_slow_internal_osc, i_fast_internal_osc,
                          i_clk_in_pin};
            in_sync_r <= in_meta_r;
            clk_in_prev_r <= in_sync_r[0];
            fast_prev_r <= in_sync_r[1];
        end
    end

    assign clk_in_s = in_sync_r[0];
    assign fast_s = in_sync_r[1];
    assign slow_s = in_sync_r[2];
    assign ready_s = in_sync_r[3];
    assign clk_in_edge = clk_in_s & ~clk_in_prev_r;
    assign fast_edge = fast_s & ~fast_prev_r;

    // ****************************************
    // Control fields
    // ****************************************
    logic [1:0] sel_r;
    logic [2:0] freq_r;
    logic [5:0] tune_r;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sel_r <= oss_pkg::SEL_RST;
        end else if (i_sel_wr) begin
            sel_r <= i_sel_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            freq_r <= oss_pkg::FREQ_RST;
        end else if (i_freq_wr) begin
            freq_r <= i_freq_data;
        end
    end

    // The trim value goes straight to the analog oscillator.
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tune_r <= oss_pkg::TUNE_RST;
        end else if (i_tune_wr) begin
            tune_r <= i_tune_data;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    logic mode_xtal;
    logic mode_pll;
    logic mode_rc;
    logic mode_int;
    logic mode_ec;

    assign mode_pll = (i_primary_mode == oss_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL_MODE);
    assign mode_xtal = (i_primary_mode == oss_pkg::MODE_LP) ||
                       (i_primary_mode == oss_pkg::MODE_XT) ||
                       (i_primary_mode == oss_pkg::MODE_HS) || mode_pll;
    assign mode_rc = (i_primary_mode == oss_pkg::MODE_RC) ||
                     (i_primary_mode == oss_pkg::MODE_RESISTOR_CAP_PIN_IO_MODE);
    assign mode_int = (i_primary_mode == oss_pkg::MODE_INTIO) ||
                      (i_primary_mode == oss_pkg::MODE_INTCK);
    assign mode_ec = !(mode_xtal || mode_rc || mode_int);

    // ****************************************
    // Start-up sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_POWER_UP_TIMER = 3'b001,
        ST_OST = 3'b010,
        ST_PLL = 3'b011,
        ST_WARM = 3'b100,
        ST_RUN = 3'b101
    } oss_state_t;

    oss_state_t state_r;
    oss_state_t go_state;
    logic [9:0] ost_cnt_r;
    logic [31:0] wait_cnt_r;
    logic [9:0] ost_last;

    assign ost_last = mode_rc ? oss_pkg::RC_LAST : oss_pkg::OST_LAST;

    always_comb begin
        if (mode_xtal || mode_rc) begin
            go_state = ST_OST;
        end else if (mode_int) begin
            go_state = ST_WARM;
        end else begin
            go_state = ST_RUN;
        end
    end

    // A stopped clock input simply produces no edges; nothing here times out,
    // so all state is kept until the clock returns.
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= i_power_up_timer_enable ? ST_POWER_UP_TIMER : go_state;
                end
                ST_POWER_UP_TIMER: begin
                    if (i_power_up_timer_expired) begin
                        state_r <= go_state;
                    end
                end
                ST_OST: begin
                    if (clk_in_edge && ost_cnt_r == ost_last) begin
                        state_r <= mode_pll ? ST_PLL : ST_RUN;
                    end
                end
                ST_PLL: begin
                    if (wait_cnt_r == 32'(PLL_CYC - 1)) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_WARM: begin
                    if (wait_cnt_r == 32'(WARM_CYCLES - 1)) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (i_wake) begin
                        state_r <= go_state;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ost_cnt_r <= 10'h000;
        end else if (state_r != ST_OST) begin
            ost_cnt_r <= 10'h000;
        end else if (clk_in_edge) begin
            ost_cnt_r <= ost_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wait_cnt_r <= 32'h0;
        end else if (state_r == ST_PLL || state_r == ST_WARM) begin
            wait_cnt_r <= wait_cnt_r + 32'h1;
        end else begin
            wait_cnt_r <= 32'h0;
        end
    end

    assign o_core_run = (state_r == ST_RUN);
    assign o_hold_pc = ~o_core_run;

    // ****************************************
    // Internal oscillator block
    // ****************************************
    logic [8:0] post_cnt_r;
    logic int_clk_r;
    logic int_prev_r;
    logic int_clk_nxt;

    assign o_fast_osc_en = (sel_r[1] && freq_r != oss_pkg::FREQ_SLOW) ||
                           (sel_r[1] && i_low_freq_source_select) ||
                           i_two_speed_startup_enable || i_fail_safe_monitor_enable ||
                           mode_int;

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            post_cnt_r <= 9'h000;
        end else if (o_fast_osc_en && fast_edge) begin
            post_cnt_r <= post_cnt_r + 9'h001;
        end
    end

    always_comb begin
        case (freq_r)
            3'h7: int_clk_nxt = fast_s;
            3'h6: int_clk_nxt = post_cnt_r[0];
            3'h5: int_clk_nxt = post_cnt_r[1];
            3'h4: int_clk_nxt = post_cnt_r[2];
            3'h3: int_clk_nxt = post_cnt_r[3];
            3'h2: int_clk_nxt = post_cnt_r[4];
            3'h1: int_clk_nxt = post_cnt_r[5];
            default: int_clk_nxt = i_low_freq_source_select ? post_cnt_r[8] : slow_s;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            int_clk_r <= 1'b0;
            int_prev_r <= 1'b0;
        end else begin
            int_clk_r <= int_clk_nxt;
            int_prev_r <= int_clk_r;
        end
    end

    assign o_int_clk = int_clk_r;

    // ****************************************
    // Quarter-rate output and pin control
    // ****************************************
    logic [1:0] q_cnt_r;
    logic q_edge;
    logic [1:0] drive;

    assign q_edge = mode_rc ? clk_in_edge : (int_clk_r & ~int_prev_r);

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            q_cnt_r <= 2'h0;
        end else if (q_edge) begin
            q_cnt_r <= q_cnt_r + 2'h1;
        end
    end

    always_comb begin
        case (i_primary_mode)
            oss_pkg::MODE_LP: drive = oss_pkg::DRIVE_LOW;
            oss_pkg::MODE_XT: drive = oss_pkg::DRIVE_MID;
            oss_pkg::MODE_HS: drive = oss_pkg::DRIVE_HIGH;
            oss_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL_MODE: drive = oss_pkg::DRIVE_HIGH;
            default: drive = oss_pkg::DRIVE_OFF;
        endcase
    end

    assign o_amp_drive = drive;
    assign o_pins.clk_in_gpio = mode_int;
    assign o_pins.clk_out_gpio = mode_ec ||
                                 (i_primary_mode == oss_pkg::MODE_RESISTOR_CAP_PIN_IO_MODE) ||
                                 (i_primary_mode == oss_pkg::MODE_INTIO);
    assign o_pins.clk_out_oe = (i_primary_mode == oss_pkg::MODE_RC) ||
                               (i_primary_mode == oss_pkg::MODE_INTCK);
    assign o_pins.clk_out = q_cnt_r[1];

    assign o_sys_clk_sel = sel_r;
    assign o_freq_sel = freq_r;
    assign o_tune = tune_r;
    assign o_status.primary_running = o_core_run && sel_r == 2'h0;
    assign o_status.fast_stable = ready_s & o_fast_osc_en;
    assign o_status.src_internal = sel_r[1];
    assign o_status.src_secondary = (sel_r == 2'h1);
    assign o_status.src_primary = (sel_r == 2'h0);

    // ****************************************
    // Assertions
    // ****************************************
    ost_release_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_OST && $past(state_r) == ST_OST && !mode_pll && !mode_rc
        ##1 state_r == ST_RUN |-> $past(ost_cnt_r) == oss_pkg::OST_LAST)
        else $error("core released before 1024 input edges");
    power_up_timer_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_POWER_UP_TIMER && !i_power_up_timer_expired |=> state_r == ST_POWER_UP_TIMER)
        else $error("start-up left power-up wait early");
    run_gate_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_RUN && i_wake && !mode_ec |=> o_hold_pc && !o_core_run)
        else $error("core not held after wake");
    pll_wait_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        $rose(o_core_run) && $past(state_r) == ST_PLL |-> $past(wait_cnt_r) == 32'(PLL_CYC - 1))
        else $error("pll wait length wrong");
    warm_wait_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        $rose(o_core_run) && $past(state_r) == ST_WARM
        |-> $past(wait_cnt_r) == 32'(WARM_CYCLES - 1))
        else $error("warm-up length wrong");
    ec_nodelay_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_IDLE && !i_power_up_timer_enable && mode_ec |=> o_core_run)
        else $error("external clock mode delayed");
    ec_pins_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        mode_ec |-> o_pins.clk_out_gpio && !o_pins.clk_out_oe)
        else $error("second pin not released");
    hs_drive_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        i_primary_mode == oss_pkg::MODE_HS |-> o_amp_drive == oss_pkg::DRIVE_HIGH)
        else $error("wrong amplifier drive");
    fast_en_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        sel_r[1] && freq_r != 3'h0 |-> o_fast_osc_en)
        else $error("fast oscillator not enabled");
    quarter_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        q_edge && q_cnt_r == 2'h1 |=> $rose(o_pins.clk_out))
        else $error("quarter clock phase wrong");
    sel_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        !i_sel_wr |=> $stable(sel_r))
        else $error("select changed without write");

    xtal_cov_c: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_OST ##1 state_r == ST_RUN);
    pll_cov_c: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_PLL ##1 state_r == ST_RUN);
    wake_cov_c: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        state_r == ST_RUN && i_wake);

endmodule

// [sim/oss_osc_model.sv]
// Behavioural oscillator sources that face the start-up block.
// Assumes the bench gates the clock-input source through i_run.
`timescale 1ns/1ps

module oss_osc_model (
    // Controls
    input wire logic i_run,
    input wire logic i_fast_en,
    // Sources and edge counts
    output logic o_clk_in,
    output logic o_fast,
    output logic o_slow,
    output logic o_ready,
    output int o_edges,
    output int o_fast_edges
);
    // ****************************************
    // Sources
    // ****************************************
    // The pin source stands still at low while stopped.
    initial begin
        o_clk_in = 1'b0;
        o_edges = 0;
        #3;
        forever begin
            #10 o_clk_in = i_run & ~o_clk_in;
            if (o_clk_in)
                o_edges++;
        end
    end

    // The fast source runs only while enabled, with a scaled period.
    initial begin
        o_fast = 1'b0;
        o_fast_edges = 0;
        #7;
        forever begin
            #20 o_fast = i_fast_en & ~o_fast;
            if (o_fast)
                o_fast_edges++;
        end
    end

    initial begin
        o_slow = 1'b0;
        forever #500 o_slow = ~o_slow;
    end

    // Ready only after some fast edges, and dropped as soon as disabled.
    initial o_ready = 1'b0;
    always @(posedge o_fast or negedge i_fast_en) begin
        o_ready <= i_fast_en && (o_fast_edges >= 8);
    end
endmodule

// [sim/oss_top_bench.sv]
// Self-checking bench for the oscillator start-up and source select block.
// Assumes the oscillator model stands on the pin side.
`timescale 1ns/1ps

module oss_top_bench;
    // ****************************************
    // Signals
    // ****************************************
    typedef struct {int lo_e; int hi_e; int lo_c; int hi_c;} oss_note_t;
    logic i_clk_sys, i_nrst, run, two_sp, fail_sf, power_up_timer_en, power_up_timer_exp, wake;
    logic sel_wr, freq_wr, tune_wr, lfss;
    logic [3:0] mode;
    logic [1:0] sel_d, amp, sys_sel;
    logic [2:0] freq_d, freq_q;
    logic [5:0] tune_d, tune_q;
    logic core_run, hold_pc, fast_en, int_clk, clk_in, fast, slow, ready;
    oss_pkg::oss_pins_t pins;
    oss_pkg::oss_status_t stat;
    int edges, fedges, n_in, n_fast, t0, e0;
    int cyc = 0;
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] lfsr;
    oss_note_t notes[$];
    oss_note_t nt;

    oss_top #(.PLL_CYC(20), .WARM_CYCLES(4)) i_dut (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_in_pin(clk_in),
        .i_fast_internal_osc(fast), .i_slow_internal_osc(slow), .i_fast_osc_ready(ready),
        .i_primary_mode(mode), .i_two_speed_startup_enable(two_sp),
        .i_fail_safe_monitor_enable(fail_sf), .i_power_up_timer_enable(power_up_timer_en),
        .i_power_up_timer_expired(power_up_timer_exp), .i_wake(wake), .i_sel_wr(sel_wr),
        .i_sel_data(sel_d), .i_freq_wr(freq_wr), .i_freq_data(freq_d),
        .i_tune_wr(tune_wr), .i_tune_data(tune_d), .i_low_freq_source_select(lfss),
        .o_core_run(core_run), .o_hold_pc(hold_pc), .o_fast_osc_en(fast_en),
        .o_int_clk(int_clk), .o_amp_drive(amp), .o_sys_clk_sel(sys_sel),
        .o_freq_sel(freq_q), .o_tune(tune_q), .o_pins(pins), .o_status(stat)
    );
    oss_osc_model i_osc (
        .i_run(run), .i_fast_en(fast_en), .o_clk_in(clk_in), .o_fast(fast),
        .o_slow(slow), .o_ready(ready), .o_edges(edges), .o_fast_edges(fedges)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic wait_run;
        for (int i = 0; i < 20000 && core_run !== 1'b1; i++)
            @(negedge i_clk_sys);
        check("started", core_run, 1'b1);
    endtask

    // Resets into a mode and notes the window in which the core must start.
    task automatic boot(input logic [3:0] m, input int le, input int he, input int lc,
                        input int hc);
        @(negedge i_clk_sys);
        i_nrst = 1'b0;
        mode = m;
        repeat (4) @(negedge i_clk_sys);
        check("reset run", core_run, 1'b0);
        check("reset sel", sys_sel, oss_pkg::SEL_RST);
        check("reset freq", freq_q, oss_pkg::FREQ_RST);
        notes.push_back('{le, he, lc, hc});
        i_nrst = 1'b1;
        t0 = cyc;
        e0 = edges;
        wait_run();
    endtask

    task automatic wr(input logic [1:0] s, input logic [2:0] f);
        @(negedge i_clk_sys);
        sel_wr = 1'b1;
        sel_d = s;
        freq_wr = 1'b1;
        freq_d = f;
        @(negedge i_clk_sys);
        sel_wr = 1'b0;
        freq_wr = 1'b0;
    endtask

    // Counts source edges across one period of the chosen output.
    task automatic period(input logic use_pin);
        int a;
        int b;
        repeat (3) begin
            a = edges;
            b = fedges;
            if (use_pin)
                @(posedge pins.clk_out);
            else
                @(posedge int_clk);
        end
        n_in = edges - a;
        n_fast = fedges - b;
        @(negedge i_clk_sys);
    endtask

    // ****************************************
    // Monitor, clock and timeout
    // ****************************************
    always @(posedge core_run) begin
        #1;
        nt = notes.pop_front();
        check("hold pc", hold_pc, 1'b0);
        check("start edges", (edges - e0) inside {[nt.lo_e:nt.hi_e]}, 1'b1);
        check("start cycles", (cyc - t0) inside {[nt.lo_c:nt.hi_c]}, 1'b1);
    end

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        i_nrst = 1'b0;
        {run, two_sp, fail_sf, power_up_timer_en, power_up_timer_exp, wake} = 6'h00;
        {sel_wr, freq_wr, tune_wr, lfss} = 4'h0;
        mode = oss_pkg::MODE_EC;
        sel_d = 2'h0;
        freq_d = 3'h0;
        tune_d = 6'h00;
        lfsr = 8'h2e;
        boot(oss_pkg::MODE_EC, 0, 0, 1, 6);
        check("ec pin", pins.clk_out_gpio, 1'b1);
        check("ec drive", amp, oss_pkg::DRIVE_OFF);
        power_up_timer_en = 1'b1;
        fork
            begin
                repeat (44) @(negedge i_clk_sys);
                power_up_timer_exp = 1'b1;
            end
        join_none
        boot(oss_pkg::MODE_EC, 0, 0, 39, 46);
        power_up_timer_en = 1'b0;
        power_up_timer_exp = 1'b0;
        run = 1'b1;
        boot(oss_pkg::MODE_XT, 1024, 1027, 0, 9000);
        check("xt drive", amp, oss_pkg::DRIVE_MID);
        wake = 1'b1;
        notes.push_back('{1024, 1027, 0, 9000});
        t0 = cyc;
        e0 = edges;
        @(negedge i_clk_sys);
        wake = 1'b0;
        @(negedge i_clk_sys);
        check("wake hold", hold_pc, 1'b1);
        run = 1'b0;
        repeat (200) @(negedge i_clk_sys);
        check("halt hold", hold_pc, 1'b1);
        run = 1'b1;
        wait_run();
        check("fast off", fast_en, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(s[1:0], oss_pkg::FREQ_RST);
            check("sel", sys_sel, s);
            check("src", stat[2:0], {s == 0, s == 1, s > 1});
            check("prim run", stat.primary_running, s == 0);
        end
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            tune_wr = 1'b1;
            tune_d = lfsr[5:0];
            @(negedge i_clk_sys);
            check("tune", tune_q, lfsr[5:0]);
        end
        tune_wr = 1'b0;
        for (int k = 7; k > 0; k--) begin
            wr(2'h2, k[2:0]);
            check("freq", freq_q, k[2:0]);
            period(1'b0);
            check("rate", n_fast, 1 << (7 - k));
        end
        lfss = 1'b1;
        wr(2'h2, oss_pkg::FREQ_SLOW);
        check("fast on", fast_en, 1'b1);
        period(1'b0);
        check("div 512", n_fast, 512);
        check("stable", stat.fast_stable, 1'b1);
        lfss = 1'b0;
        period(1'b0);
        check("fast idle", fast_en, 1'b0);
        check("slow src", n_fast, 0);
        check("unstable", stat.fast_stable, 1'b0);
        for (int b = 0; b < 2; b++) begin
            two_sp = b == 0;
            fail_sf = b == 1;
            @(negedge i_clk_sys);
            check("fast req", fast_en, 1'b1);
        end
        fail_sf = 1'b0;
        boot(oss_pkg::MODE_LP, 1024, 1027, 0, 9000);
        check("lp drive", amp, oss_pkg::DRIVE_LOW);
        boot(oss_pkg::MODE_HS, 1024, 1027, 0, 9000);
        check("hs mode drive", amp, oss_pkg::DRIVE_HIGH);
        boot(oss_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL_MODE, 1028, 1033, 0, 9000);
        check("hs drive", amp, oss_pkg::DRIVE_HIGH);
        boot(oss_pkg::MODE_RC, 8, 11, 0, 300);
        period(1'b1);
        check("rc out", n_in, 4);
        check("rc oe", pins.clk_out_oe, 1'b1);
        boot(oss_pkg::MODE_RESISTOR_CAP_PIN_IO_MODE, 8, 11, 0, 300);
        check("resistor_cap_pin_io_mode pins", {pins.clk_out_gpio, pins.clk_out_oe}, 2'h2);
        run = 1'b0;
        boot(oss_pkg::MODE_INTCK, 0, 0, 5, 14);
        check("int en", fast_en, 1'b1);
        period(1'b1);
        check("int out", n_fast, 4 << (7 - oss_pkg::FREQ_RST));
        check("int pins", {pins.clk_in_gpio, pins.clk_out_oe}, 2'h3);
        boot(oss_pkg::MODE_INTIO, 0, 0, 5, 14);
        check("io pins", {pins.clk_in_gpio, pins.clk_out_gpio}, 2'h3);
        wrap_up();
    end
endmodule
